// ==== abx_pkg.sv ====
// Shared constants and types for the ALU, bit and branch execution unit.
// Assumes an APB master with 32-bit data and a 12-bit byte address.
package abx_pkg;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_COMPARE_REGISTER_TO_ACCUMULATOR = 4'h1,
    OP_BIT_CLEAR_REGISTER = 4'h2,
    OP_BIT_SET_REGISTER = 4'h3,
    OP_BIT_TEST_SKIP_IF_ZERO = 4'h4,
    OP_BIT_TEST_SKIP_IF_ONE = 4'h5,
    OP_LONG_SUBROUTINE_JUMP = 4'h6,
    OP_LONG_BRANCH = 4'h7,
    OP_ADD_REGISTER_WITH_CARRY = 4'h8,
    OP_ADD_REGISTER = 4'h9,
    OP_ADD_IMMEDIATE_WITH_CARRY = 4'ha,
    OP_ADD_IMMEDIATE = 4'hb,
    OP_AND_REGISTER = 4'hc
  } abx_op_t;

  typedef enum logic [1:0] {
    PAGE_PRIMARY = 2'h0,
    PAGE_PORT = 2'h1,
    PAGE_SPECIAL = 2'h2
  } abx_page_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_EXEC = 2'h1,
    ST_SECOND = 2'h2
  } abx_state_t;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam int APB_AW = 12;
  localparam logic [11:0] OFS_INSN = 12'h000;
  localparam logic [11:0] OFS_ACC = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;
  localparam logic [11:0] OFS_PC = 12'h00c;
  localparam logic [11:0] OFS_TOS = 12'h010;
  localparam logic [11:0] OFS_CYCLES = 12'h014;
  localparam logic [2:0] RF_WINDOW_SEL = 3'h1;
  localparam logic [6:0] RF_DEPTH = 7'h60;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int INSN_W = 27;
  localparam int INSN_OP_LSB = 0;
  localparam int INSN_PAGE_LSB = 4;
  localparam int INSN_REG_LSB = 6;
  localparam int INSN_BIT_LSB = 12;
  localparam int INSN_DEST_BIT = 15;
  localparam int INSN_IMM_LSB = 16;
  localparam int INSN_TGT_LSB = 16;
  localparam int STS_C_BIT = 0;
  localparam int STS_DC_BIT = 1;
  localparam int STS_Z_BIT = 2;
  localparam int STS_BUSY_BIT = 8;
  localparam int STS_REFUSED_BIT = 9;
  localparam int STS_SKIP_BIT = 10;

  // ****************************************
  // Pages, reset values, cycle counts
  // ****************************************
  localparam logic [3:0] PORT_FIRST = 4'h5;
  localparam logic [6:0] PORT_BASE = 7'h40;
  localparam logic [6:0] SPECIAL_BASE = 7'h50;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [10:0] PC_RST = 11'h000;
  localparam logic [10:0] PC_STEP = 11'h001;
  localparam logic [10:0] PC_SKIP_STEP = 11'h002;
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;

endpackage

// ==== abx_regfile.sv ====
// Register pages held in flip-flops: primary, port-control and special pages.
// Assumes the caller never writes from two sources in one cycle.
`timescale 1ns/100ps
`default_nettype none
module abx_regfile (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_en,
  input wire logic [6:0] wr_idx,
  input wire logic [7:0] wr_data,
  input wire logic [6:0] rd_a_idx,
  output logic [7:0] rd_a_data,
  input wire logic [6:0] rd_b_idx,
  output logic [7:0] rd_b_data
);
  import abx_pkg::*;

  typedef struct packed {
    logic [95:0][7:0] mem;
  } abx_rf_state_t;

  abx_rf_state_t s_q;
  abx_rf_state_t s_d;

  // Indexes past the last page read as zero
  assign rd_a_data = (rd_a_idx < RF_DEPTH) ? s_q.mem[rd_a_idx] : 8'h00;
  assign rd_b_data = (rd_b_idx < RF_DEPTH) ? s_q.mem[rd_b_idx] : 8'h00;

  // Single write port
  always_comb
  begin
    s_d = s_q;
    if (wr_en && (wr_idx < RF_DEPTH))
    begin
      s_d.mem[wr_idx] = wr_data;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end
endmodule
`default_nettype wire

// ==== abx_alu.sv ====
// Combinational datapath: adds, compare, AND, bit force and bit test.
// Assumes the caller picks which flags to keep for each operation.
`timescale 1ns/100ps
`default_nettype none
module abx_alu (
  input wire abx_pkg::abx_op_t op,
  input wire logic [7:0] acc,
  input wire logic [7:0] opnd,
  input wire logic c_in,
  input wire logic [2:0] bit_sel,
  output logic [7:0] result,
  output logic c_out,
  output logic dc_out,
  output logic z_out,
  output logic bit_val
);
  import abx_pkg::*;

  // Returns {carry out of bit 7, carry out of bit 3, sum}
  function automatic logic [9:0] add_fn(input logic [7:0] a, input logic [7:0] b,
                                        input logic ci);
    logic [4:0] lo;
    logic [8:0] full;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    full = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    return {full[8], lo[4], full[7:0]};
  endfunction

  logic [9:0] sum;

  // Operation select
  always_comb
  begin
    sum = 10'h000;
    result = opnd;
    case (op)
      OP_COMPARE_REGISTER_TO_ACCUMULATOR: sum = add_fn(opnd, ~acc, 1'b1); // see (RQ1)
      OP_ADD_REGISTER_WITH_CARRY: sum = add_fn(acc, opnd, c_in); // see (RQ13)
      OP_ADD_REGISTER: sum = add_fn(acc, opnd, 1'b0); // see (RQ14)
      OP_ADD_IMMEDIATE_WITH_CARRY: sum = add_fn(acc, opnd, c_in); // see (RQ15)
      OP_ADD_IMMEDIATE: sum = add_fn(acc, opnd, 1'b0); // see (RQ16)
      default: sum = 10'h000;
    endcase
    case (op)
      OP_AND_REGISTER: result = acc & opnd; // see (RQ17)
      OP_BIT_CLEAR_REGISTER: result[bit_sel] = 1'b0; // see (RQ2)
      OP_BIT_SET_REGISTER: result[bit_sel] = 1'b1; // see (RQ2)
      OP_COMPARE_REGISTER_TO_ACCUMULATOR, OP_ADD_REGISTER_WITH_CARRY, OP_ADD_REGISTER,
      OP_ADD_IMMEDIATE_WITH_CARRY, OP_ADD_IMMEDIATE: result = sum[7:0];
      default: result = opnd;
    endcase
  end

  // Carry is no-borrow on compare since it adds the complement
  assign c_out = sum[9]; // see (RQ18)
  assign dc_out = sum[8]; // see (RQ18)
  assign z_out = (result == 8'h00); // see (RQ19)
  assign bit_val = opnd[bit_sel];
endmodule
`default_nettype wire

// ==== abx_exec_top.sv ====
// Execution unit for compare, bit, long branch, add and AND instructions,
// with the accumulator, flags, program counter and register pages behind APB.
// Assumes a single 20 MHz clock and an APB master that waits for pready.
//
// Functional notes
// (RQ1) Compare computes register minus accumulator, sets Z and C only, stores nothing.
// (RQ2) Bit clear/set forces one register bit, other bits and flags untouched.
// (RQ3) Bit test skips next instruction when the bit is 0, taking two cycles.
// (RQ4) Bit test skips next instruction when the bit is 1, taking two cycles.
// (RQ5) A taken skip discards the fetched instruction and runs a no-op.
// (RQ6) Long call pushes return address, loads PC bits 10..0, two cycles.
// (RQ7) Long branch loads PC bits 10..0 from the target, stack untouched.
// (RQ8) Destination bit 0 sends the result to the accumulator only.
// (RQ9) Destination bit 1 writes the result back to the register only.
// (RQ10) Primary page uses a 6-bit register field, 0x00 to 0x3F.
// (RQ11) Port-control page accepts only 0x5 to 0xF.
// (RQ12) Special page uses a 4-bit field, 0x0 to 0xF.
// (RQ13) Add register with carry updates Z, DC, C and follows destination.
// (RQ14) Add register without carry updates Z, DC, C and follows destination.
// (RQ15) Add immediate with carry writes the accumulator, updates Z, DC, C.
// (RQ16) Add immediate writes the accumulator ignoring carry, updates Z, DC, C.
// (RQ17) AND register follows destination and updates only Z.
// (RQ18) DC is carry out of bit 3; C carry out of bit 7 or no-borrow.
// (RQ19) Z is set when the 8-bit result is zero, else cleared.
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module abx_exec_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [abx_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr
);
  import abx_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    abx_state_t st;
    logic [INSN_W-1:0] insn;
    logic [7:0] acc;
    logic fc;
    logic fdc;
    logic fz;
    logic [10:0] pc;
    logic [10:0] tos;
    logic [1:0] cycles;
    logic refused;
    logic skipped;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } abx_top_state_t;

  abx_top_state_t s_q;
  abx_top_state_t s_d;

  // Maps page and field to {legal, flat index}
  function automatic logic [7:0] map_reg(input abx_page_t pg, input logic [5:0] ra);
    logic ok;
    logic [6:0] idx;
    ok = 1'b0;
    idx = 7'h00;
    case (pg)
      PAGE_PRIMARY:
      begin
        ok = 1'b1; // see (RQ10)
        idx = {1'b0, ra};
      end
      PAGE_PORT:
      begin
        ok = (ra[5:4] == 2'h0) && (ra[3:0] >= PORT_FIRST); // see (RQ11)
        idx = PORT_BASE + {3'h0, ra[3:0]};
      end
      PAGE_SPECIAL:
      begin
        ok = (ra[5:4] == 2'h0); // see (RQ12)
        idx = SPECIAL_BASE + {3'h0, ra[3:0]};
      end
      default:
      begin
        ok = 1'b0;
        idx = 7'h00;
      end
    endcase
    return {ok, idx};
  endfunction

  // ****************************************
  // Instruction fields
  // ****************************************
  abx_op_t ex_op;
  abx_page_t ex_page;
  logic [5:0] ex_reg;
  logic [2:0] ex_bit;
  logic ex_dest;
  logic [7:0] ex_imm;
  logic [10:0] ex_tgt;
  logic [7:0] ex_map;
  logic ex_ok;
  logic ex_uses_reg;
  logic ex_dest_op;
  logic ex_imm_op;
  logic ex_add_op;
  logic in_exec;

  assign ex_op = abx_op_t'(s_q.insn[INSN_OP_LSB +: 4]);
  assign ex_page = abx_page_t'(s_q.insn[INSN_PAGE_LSB +: 2]);
  assign ex_reg = s_q.insn[INSN_REG_LSB +: 6];
  assign ex_bit = s_q.insn[INSN_BIT_LSB +: 3];
  assign ex_dest = s_q.insn[INSN_DEST_BIT];
  assign ex_imm = s_q.insn[INSN_IMM_LSB +: 8];
  assign ex_tgt = s_q.insn[INSN_TGT_LSB +: 11];
  assign ex_map = map_reg(ex_page, ex_reg);
  assign ex_ok = ex_map[7];
  assign in_exec = (s_q.st == ST_EXEC);
  // Ops whose result may go to either place
  assign ex_dest_op = (ex_op == OP_ADD_REGISTER_WITH_CARRY) || (ex_op == OP_ADD_REGISTER)
                      || (ex_op == OP_AND_REGISTER);
  assign ex_imm_op = (ex_op == OP_ADD_IMMEDIATE_WITH_CARRY) || (ex_op == OP_ADD_IMMEDIATE);
  assign ex_add_op = ex_imm_op || (ex_op == OP_ADD_REGISTER_WITH_CARRY)
                     || (ex_op == OP_ADD_REGISTER);
  assign ex_uses_reg = ex_dest_op || (ex_op == OP_COMPARE_REGISTER_TO_ACCUMULATOR)
                       || (ex_op == OP_BIT_CLEAR_REGISTER) || (ex_op == OP_BIT_SET_REGISTER)
                       || (ex_op == OP_BIT_TEST_SKIP_IF_ZERO)
                       || (ex_op == OP_BIT_TEST_SKIP_IF_ONE);

  // ****************************************
  // Datapath
  // ****************************************
  logic [7:0] rf_rdata;
  logic [7:0] rf_bdata;
  logic rf_we;
  logic [6:0] rf_widx;
  logic [7:0] rf_wdata;
  logic [7:0] alu_res;
  logic alu_c;
  logic alu_dc;
  logic alu_z;
  logic alu_bit;

  abx_regfile u_rf (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(rf_we),
    .wr_idx(rf_widx),
    .wr_data(rf_wdata),
    .rd_a_idx(ex_map[6:0]),
    .rd_a_data(rf_rdata),
    .rd_b_idx(paddr[8:2]),
    .rd_b_data(rf_bdata)
  );

  abx_alu u_alu (
    .op(ex_op),
    .acc(s_q.acc),
    .opnd(ex_imm_op ? ex_imm : rf_rdata),
    .c_in(s_q.fc),
    .bit_sel(ex_bit),
    .result(alu_res),
    .c_out(alu_c),
    .dc_out(alu_dc),
    .z_out(alu_z),
    .bit_val(alu_bit)
  );

  // ****************************************
  // APB decode
  // ****************************************
  logic apb_done;
  logic rf_hit;
  logic hit;
  logic [31:0] rd_word;

  assign apb_done = psel & penable & s_q.pready;
  assign rf_hit = (paddr[11:9] == RF_WINDOW_SEL) && (paddr[8:2] < RF_DEPTH);

  // Read mux; unmapped addresses answer with an error
  always_comb
  begin
    hit = 1'b1;
    rd_word = 32'h0000_0000;
    if (rf_hit)
    begin
      rd_word[7:0] = rf_bdata;
    end
    else
    begin
      case (paddr)
        OFS_INSN: rd_word[INSN_W-1:0] = s_q.insn;
        OFS_ACC: rd_word[7:0] = s_q.acc;
        OFS_STATUS:
        begin
          rd_word[STS_C_BIT] = s_q.fc;
          rd_word[STS_DC_BIT] = s_q.fdc;
          rd_word[STS_Z_BIT] = s_q.fz;
          rd_word[STS_BUSY_BIT] = (s_q.st != ST_IDLE);
          rd_word[STS_REFUSED_BIT] = s_q.refused;
          rd_word[STS_SKIP_BIT] = s_q.skipped;
        end
        OFS_PC: rd_word[10:0] = s_q.pc;
        OFS_TOS: rd_word[10:0] = s_q.tos;
        OFS_CYCLES: rd_word[1:0] = s_q.cycles;
        default: hit = 1'b0;
      endcase
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    s_d = s_q;
    rf_we = 1'b0;
    rf_widx = ex_map[6:0];
    rf_wdata = alu_res;
    // Answer only while idle, so reads never race an instruction
    s_d.pready = psel & ~s_q.pready & (s_q.st == ST_IDLE);
    s_d.prdata = 32'h0000_0000;
    s_d.pslverr = 1'b0;
    if (s_d.pready)
    begin
      s_d.prdata = rd_word;
      s_d.pslverr = ~hit;
    end
    // Register writes land at the completing edge
    if (apb_done && pwrite && hit)
    begin
      if (rf_hit)
      begin
        rf_we = 1'b1;
        rf_widx = paddr[8:2];
        rf_wdata = pwdata[7:0];
      end
      else
      begin
        case (paddr)
          OFS_INSN:
          begin
            s_d.insn = pwdata[INSN_W-1:0];
            s_d.st = ST_EXEC;
          end
          OFS_ACC: s_d.acc = pwdata[7:0];
          OFS_STATUS:
          begin
            s_d.fc = pwdata[STS_C_BIT];
            s_d.fdc = pwdata[STS_DC_BIT];
            s_d.fz = pwdata[STS_Z_BIT];
            s_d.refused = s_q.refused & ~pwdata[STS_REFUSED_BIT];
          end
          OFS_PC: s_d.pc = pwdata[10:0];
          default: s_d.insn = s_q.insn;
        endcase
      end
    end
    case (s_q.st)
      ST_EXEC:
      begin
        s_d.st = ST_IDLE;
        s_d.cycles = CYC_ONE;
        s_d.skipped = 1'b0;
        if (ex_uses_reg && !ex_ok)
        begin
          s_d.refused = 1'b1; // see (RQ11)
        end
        else
        begin
          s_d.pc = 11'(s_q.pc + PC_STEP);
          // Flag updates per operation
          if (ex_add_op || (ex_op == OP_COMPARE_REGISTER_TO_ACCUMULATOR))
          begin
            s_d.fc = alu_c; // see (RQ18)
            s_d.fz = alu_z; // see (RQ19)
          end
          if (ex_add_op)
          begin
            s_d.fdc = alu_dc; // see (RQ13) (RQ14) (RQ15) (RQ16)
          end
          if (ex_op == OP_AND_REGISTER)
          begin
            s_d.fz = alu_z; // see (RQ17)
          end
          case (ex_op)
            OP_BIT_CLEAR_REGISTER, OP_BIT_SET_REGISTER: rf_we = 1'b1; // see (RQ2)
            OP_ADD_IMMEDIATE_WITH_CARRY, OP_ADD_IMMEDIATE: s_d.acc = alu_res; // see (RQ15) (RQ16)
            OP_ADD_REGISTER_WITH_CARRY, OP_ADD_REGISTER, OP_AND_REGISTER:
            begin
              if (ex_dest)
              begin
                rf_we = 1'b1; // see (RQ9)
              end
              else
              begin
                s_d.acc = alu_res; // see (RQ8)
              end
            end
            OP_BIT_TEST_SKIP_IF_ZERO, OP_BIT_TEST_SKIP_IF_ONE:
            begin
              // Skip drops the fetched word and spends a no-op cycle
              if (alu_bit == (ex_op == OP_BIT_TEST_SKIP_IF_ONE)) // see (RQ3) (RQ4)
              begin
                s_d.pc = 11'(s_q.pc + PC_SKIP_STEP); // see (RQ5)
                s_d.skipped = 1'b1;
                s_d.cycles = CYC_TWO;
                s_d.st = ST_SECOND;
              end
            end
            OP_LONG_SUBROUTINE_JUMP:
            begin
              s_d.tos = 11'(s_q.pc + PC_STEP); // see (RQ6)
              s_d.pc = ex_tgt;
              s_d.cycles = CYC_TWO;
              s_d.st = ST_SECOND;
            end
            OP_LONG_BRANCH:
            begin
              s_d.pc = ex_tgt; // see (RQ7)
              s_d.cycles = CYC_TWO;
              s_d.st = ST_SECOND;
            end
            default: rf_we = 1'b0; // see (RQ1)
          endcase
        end
      end
      ST_SECOND: s_d.st = ST_IDLE;
      default: s_d.st = s_d.st;
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q <= '0;
      s_q.acc <= ACC_RST;
      s_q.pc <= PC_RST;
      s_q.st <= ST_IDLE;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign pready = s_q.pready;
  assign prdata = s_q.prdata;
  assign pslverr = s_q.pslverr;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_cmp_no_store: assert property (in_exec && ex_op == OP_COMPARE_REGISTER_TO_ACCUMULATOR // see (RQ1)
    |-> !rf_we ##1 ($stable(s_q.acc) && $stable(s_q.fdc) && s_q.st == ST_IDLE))
    else $error("compare stored a result or changed DC");
  chk_bit_force: assert property (in_exec && ex_ok && ex_op == OP_BIT_SET_REGISTER // see (RQ2)
    |-> rf_we && (rf_wdata == (rf_rdata | (8'h01 << ex_bit)))
    ##1 ($stable(s_q.fz) && $stable(s_q.fc)))
    else $error("bit set touched other bits or flags");
  chk_skip_zero: assert property (in_exec && ex_ok && ex_op == OP_BIT_TEST_SKIP_IF_ZERO // see (RQ3)
    && !alu_bit |=> s_q.st == ST_SECOND ##1 (s_q.st == ST_IDLE && s_q.cycles == CYC_TWO))
    else $error("skip on zero did not take two cycles");
  chk_skip_one: assert property (in_exec && ex_ok && ex_op == OP_BIT_TEST_SKIP_IF_ONE // see (RQ4)
    |=> s_q.pc == 11'($past(s_q.pc) + ($past(alu_bit) ? PC_SKIP_STEP : PC_STEP)))
    else $error("skip on one advanced PC wrongly");
  chk_long_call: assert property (in_exec && ex_op == OP_LONG_SUBROUTINE_JUMP // see (RQ6)
    |=> (s_q.tos == 11'($past(s_q.pc) + PC_STEP) && s_q.pc == $past(ex_tgt))
    ##1 s_q.st == ST_IDLE)
    else $error("long call push or target wrong");
  chk_long_branch: assert property (in_exec && ex_op == OP_LONG_BRANCH // see (RQ7)
    |=> s_q.pc == $past(ex_tgt) && $stable(s_q.tos) && s_q.st == ST_SECOND)
    else $error("long branch wrong");
  chk_dest_acc: assert property (in_exec && ex_ok && ex_dest_op && !ex_dest // see (RQ8)
    |-> !rf_we ##1 s_q.acc == $past(alu_res))
    else $error("destination 0 did not reach accumulator");
  chk_dest_reg: assert property (in_exec && ex_ok && ex_dest_op && ex_dest // see (RQ9)
    |-> rf_we ##1 $stable(s_q.acc))
    else $error("destination 1 changed accumulator");
  chk_port_range: assert property (in_exec && ex_uses_reg && ex_page == PAGE_PORT // see (RQ11)
    && ex_reg[3:0] < PORT_FIRST |-> !rf_we ##1 (s_q.refused && $stable(s_q.pc)))
    else $error("illegal port address executed");
  chk_adc_imm: assert property (in_exec && ex_op == OP_ADD_IMMEDIATE_WITH_CARRY // see (RQ15)
    |=> s_q.acc == 8'($past(s_q.acc) + $past(ex_imm) + {7'h00, $past(s_q.fc)})
    && s_q.fz == (s_q.acc == 8'h00))
    else $error("immediate add with carry wrong");
  chk_and_flags: assert property (in_exec && ex_ok && ex_op == OP_AND_REGISTER // see (RQ17)
    |=> $stable(s_q.fc) && $stable(s_q.fdc))
    else $error("AND changed carry flags");
endmodule
`default_nettype wire

// ==== abx_tb.sv ====
// Self-checking bench for the execution unit, driven over APB by the bench.
// Assumes one-word registers and an answer with a single-cycle pready.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import abx_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [APB_AW-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int error_cnt, total_checks, cyc, seed;
  int acc, c, dc, z, pc, tos, sk, ncyc;
  int mem [96];

  abx_exec_top i_abx_exec_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr)
  );

  // ****************************************
  // Clock and hang limit
  // ****************************************
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // Whole run needs about 4000 cycles; ceiling leaves ample slack
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end

  // ****************************************
  // Bus tasks and comparison
  // ****************************************
  task automatic report_and_stop();
    if (error_cnt == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (e !== g)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Outputs read in the edge's own step show what that edge sampled; no wait limit here
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e,
                      input logic [31:0] m);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, e & m, rd & m);
  endtask

  // ****************************************
  // Reference model of one instruction
  // ****************************************
  // A negative rv or av asks for a random register or accumulator value
  task automatic run(input int op, pg, ra, b, d, im, rv, av);
    int ix, ok, go, s, o, ci, res;
    ix = (pg == 0) ? ra : (pg == 1) ? 64 + ra : 80 + ra;
    ok = pg == 0 || (pg == 1 && ra >= 5 && ra <= 15) || (pg == 2 && ra <= 15);
    // Only register-operand instructions can be refused for their page
    go = ok || !(op inside {[1:5], 8, 9, 12});
    if (rv < 0)
      rv = $urandom % 256;
    if (av < 0)
      av = $urandom % 256;
    acc = av;
    c = $urandom % 2;
    dc = $urandom % 2;
    z = $urandom % 2;
    if (ok)
    begin
      mem[ix] = rv;
      apb(1'b1, 12'(12'h200 + 4 * ix), rv);
    end
    apb(1'b1, OFS_ACC, acc);
    apb(1'b1, OFS_STATUS, 32'h0000_0200 | z << 2 | dc << 1 | c);
    sk = 0;
    ncyc = 1;
    if (go)
    begin
      case (op)
        1:
        begin
          res = (rv - acc) & 255;
          c = rv >= acc;
          z = res == 0;
        end
        2: mem[ix] = rv & ~(1 << b);
        3: mem[ix] = rv | (1 << b);
        4: sk = ((rv >> b) & 1) == 0;
        5: sk = (rv >> b) & 1;
        6, 7:
        begin
          if (op == 6)
            tos = (pc + 1) & 2047;
          pc = im - 1;
          ncyc = 2;
        end
        8, 9, 10, 11, 12:
        begin
          o = (op == 10 || op == 11) ? im : rv;
          ci = (op == 8 || op == 10) ? c : 0;
          s = (op == 12) ? (acc & o) : acc + o + ci;
          res = s & 255;
          z = res == 0;
          if (op != 12)
          begin
            dc = (acc & 15) + (o & 15) + ci > 15;
            c = s > 255;
          end
          if (d == 1 && op != 10 && op != 11)
            mem[ix] = res;
          else
            acc = res;
        end
        default: ;
      endcase
      if (sk)
        ncyc = 2;
      pc = (pc + 1 + sk) & 2047;
    end
    apb(1'b1, OFS_INSN, op | pg << 4 | ra << 6 | b << 12 | d << 15 | im << 16);
    rchk("acc", OFS_ACC, acc, 32'hffff_ffff);
    rchk("status", OFS_STATUS, (go ? 0 : 32'h200) | sk << 10 | z << 2 | dc << 1 | c,
         go ? 32'hffff_ffff : 32'h0000_0207);
    rchk("pc", OFS_PC, pc, 32'hffff_ffff);
    rchk("tos", OFS_TOS, tos, 32'hffff_ffff);
    if (go)
      rchk("cycles", OFS_CYCLES, ncyc, 32'hffff_ffff);
    if (ok)
      rchk("page", 12'(12'h200 + 4 * ix), mem[ix], 32'hffff_ffff);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    presetn = 1'b0;
    seed = $urandom(90);
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset contents, unmapped access, read-only stack top
    for (int a = 4; a <= 16; a += 4)
      rchk("reset", 12'(a), 0, 32'hffff_ffff);
    rchk("reset page", 12'h2fc, 0, 32'hffff_ffff);
    apb(1'b0, 12'h100, 32'h0000_0000);
    chk("slverr", 1, err);
    chk("unmapped", 0, rd);
    apb(1'b1, OFS_TOS, 32'h0000_07ff);
    rchk("tos ro", OFS_TOS, 0, 32'hffff_ffff);
    // Boundary cases: equal compare, borrow, zero sums, page edges, refusals
    run(1, 0, 63, 0, 0, 0, 8'h40, 8'h40);
    run(1, 0, 0, 0, 0, 0, 8'h3f, 8'h40);
    run(8, 0, 9, 0, 1, 0, 8'h34, 8'h12);
    run(11, 0, 0, 0, 0, 8'h01, 0, 8'hff);
    run(9, 0, 1, 0, 0, 0, 8'h0f, 8'h01);
    run(12, 1, 5, 0, 1, 0, 8'haf, 8'h5a);
    run(2, 1, 15, 7, 0, 0, -1, -1);
    run(3, 2, 0, 0, 0, 0, -1, -1);
    run(5, 2, 15, 7, 0, 0, 8'h80, -1);
    run(4, 0, 2, 3, 0, 0, 8'hf7, -1);
    run(4, 1, 4, 0, 0, 0, 0, -1);
    run(4, 2, 16, 0, 0, 0, 0, -1);
    run(7, 3, 0, 0, 0, 11'h123, 0, -1);
    run(1, 3, 5, 0, 0, 0, -1, -1);
    run(6, 0, 0, 0, 0, 11'h7ff, -1, -1);
    run(0, 0, 0, 0, 0, 0, -1, -1);
    // Random sweep over every operation code, both destinations
    for (int i = 0; i < 130; i++)
      run(i % 13, 0, $urandom % 64, $urandom % 8, $urandom % 2,
          (i % 13 >= 10) ? $urandom % 256 : $urandom % 2048, -1, -1);
    report_and_stop();
  end
endmodule
`default_nettype wire
